// File: include/pei_cfg.svh
// Constants for the port event and interrupt block: register indices,
// summary bit positions, reset values and bus answers.
// Assumes an 8-bit AXI4-Lite byte address, one 32-bit word per register.
//
// Overview of operation
// (R1) Summary bit 0 is set while any port switch-change flag is set.
// (R2) Summary bit 1 is set while any power-good change flag is set.
// (R3) Summary bit 2 is set while any overload-timeout fault flag is set.
// (R4) Summary bit 3 is set while any signature-detection-done flag is set.
// (R5) Summary bit 4 is set while any classification-done flag is set.
// (R6) Summary bit 5 is set while any unplug-timeout fault flag is set.
// (R7) Summary bit 6 is set while any start-up or limit event flag is set.
// (R8) Summary bit 7 is set while any supply event flag is set.
// (R9) Writable mask, same layout as summary; only unmasked groups pull the pin low.
// (R10) Power event bits 3:0 flag per-port switch on or off.
// (R11) Power event bits 7:4 flag per-port power-good state change.
// (R12) Power events have a clear-on-read view; reading it clears both views.
// (R13) Signature event bits 3:0 flag per-port signature detection complete.
// (R14) Signature event bits 7:4 flag per-port classification complete.
// (R15) Signature events have a clear-on-read view; reading it clears both views.
// (R16) Fault bits 3:0 flag per-port shutoff after overload beyond its time limit.
// (R17) Fault bits 7:4 flag per-port unplug timeout after current drops.
// (R18) Fault events have a clear-on-read view; reading it clears both views.
// (R19) Start-up bits 3:0 flag inrush shutoffs, bits 7:4 limit timeout shutoffs.
// (R20) Supply bit 7 over-temperature, bit 5 logic undervoltage, bit 4 HV undervoltage.
// (R21) Flags stay set until their clear-on-read view is read; same-cycle events kept.
// (R22) Interrupt pin low while summary AND mask is non-zero, released otherwise.
`ifndef PEI_CFG_SVH
`define PEI_CFG_SVH

`define PEI_ADDR_W 8
`define PEI_IDX_SUMMARY 6'h00
`define PEI_IDX_MASK 6'h01
`define PEI_IDX_PWR 6'h02
`define PEI_IDX_PWR_COR 6'h03
`define PEI_IDX_SIG 6'h04
`define PEI_IDX_SIG_COR 6'h05
`define PEI_IDX_FLT 6'h06
`define PEI_IDX_FLT_COR 6'h07
`define PEI_IDX_START 6'h08
`define PEI_IDX_START_COR 6'h09
`define PEI_IDX_SUP 6'h0a
`define PEI_IDX_SUP_COR 6'h0b
`define PEI_IDX_LAST 6'h0b

`define PEI_SUM_PWR_SW 0
`define PEI_SUM_PWR_GOOD 1
`define PEI_SUM_OVERLOAD 2
`define PEI_SUM_SIG 3
`define PEI_SUM_CLASS 4
`define PEI_SUM_UNPLUG 5
`define PEI_SUM_START 6
`define PEI_SUM_SUPPLY 7

`define PEI_SUP_TEMP 7
`define PEI_SUP_UV_VDD 5
`define PEI_SUP_UV_VEE 4

`define PEI_MASK_RST 8'h00
`define PEI_FLAG_RST 1'h0
`define PEI_RESP_OKAY 2'h0
`define PEI_RESP_SLVERR 2'h2

`endif

// File: include/pei_pkg.sv
// Types shared by the event and interrupt block.
// Assumes nothing beyond the constants header.
package pei_pkg;

	// One byte per event register, supply byte highest
	typedef struct packed {
		logic [7:0] supply;
		logic [7:0] startup;
		logic [7:0] fault;
		logic [7:0] sigclass;
		logic [7:0] power;
	} pei_evt_t;

	typedef enum logic [1:0] {
		PEI_W_IDLE = 2'h1,
		PEI_W_RESP = 2'h2
	} pei_wstate_t;

	typedef enum logic [1:0] {
		PEI_R_IDLE = 2'h1,
		PEI_R_DATA = 2'h2
	} pei_rstate_t;

endpackage

// File: rtl/pei_event_top.sv
// Event flags, group summary, interrupt mask and interrupt pin of a
// four-port power-sourcing controller, reached over AXI4-Lite.
// Assumes raw event lines are asynchronous levels whose rising edge
// marks one event; the pin is open drain with a pull-up outside.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "pei_cfg.svh"
module pei_event_top
	import pei_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic [7:0] AWADDR,
	input wire logic [2:0] AWPROT,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic [2:0] ARPROT,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	input wire logic [3:0] EVT_PWR_SWITCH,
	input wire logic [3:0] EVT_PWR_GOOD,
	input wire logic [3:0] EVT_SIG_DONE,
	input wire logic [3:0] EVT_CLASS_DONE,
	input wire logic [3:0] EVT_OVERLOAD,
	input wire logic [3:0] EVT_UNPLUG,
	input wire logic [3:0] EVT_INRUSH,
	input wire logic [3:0] EVT_LIMIT,
	input wire logic EVT_OVERTEMP,
	input wire logic EVT_VDD_UV,
	input wire logic EVT_VEE_UV,
	output logic IRQ_N,
	output logic IRQ_N_OE
);
	pei_evt_t raw;
	pei_evt_t rise;
	pei_evt_t flags;
	pei_evt_t clr;
	logic [7:0] summary;
	logic [7:0] mask_q;
	logic irq_n_q;
	logic irq_oe_q;

	pei_wstate_t wstate_q;
	logic awready_q;
	logic wready_q;
	logic aw_got_q;
	logic w_got_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic wr_fire;
	logic [5:0] wr_idx;

	pei_rstate_t rstate_q;
	logic arready_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic rd_take;
	logic [5:0] rd_idx;
	logic cor_pwr;
	logic cor_sig;
	logic cor_flt;
	logic cor_start;
	logic cor_sup;

	// Raw event lines gathered by register byte
	always_comb begin
		raw = '0;
		// (R10) switch events
		raw.power[3:0] = EVT_PWR_SWITCH;
		// (R11) power-good changes
		raw.power[7:4] = EVT_PWR_GOOD;
		// (R13) signature done
		raw.sigclass[3:0] = EVT_SIG_DONE;
		// (R14) class done
		raw.sigclass[7:4] = EVT_CLASS_DONE;
		// (R16) overload shutoffs
		raw.fault[3:0] = EVT_OVERLOAD;
		// (R17) unplug timeouts
		raw.fault[7:4] = EVT_UNPLUG;
		// (R19) inrush and limit
		raw.startup[3:0] = EVT_INRUSH;
		raw.startup[7:4] = EVT_LIMIT;
		// (R20) supply bits, reserved zero
		raw.supply[`PEI_SUP_TEMP] = EVT_OVERTEMP;
		raw.supply[`PEI_SUP_UV_VDD] = EVT_VDD_UV;
		raw.supply[`PEI_SUP_UV_VEE] = EVT_VEE_UV;
	end

	pei_evt_sync #(
		.W($bits(pei_evt_t))
	) u_sync (
		.clk(CORE_CLK),
		.rst_n(NRST),
		.lvl(raw),
		.rise(rise)
	);

	pei_flag_bank #(
		.W($bits(pei_evt_t))
	) u_flags (
		.clk(CORE_CLK),
		.rst_n(NRST),
		.set(rise),
		.clr(clr),
		.flags(flags)
	);

	// Clear pulses come from the read address handshake
	assign rd_take = ARVALID & arready_q;
	assign rd_idx = ARADDR[7:2];
	// (R12) power view clear
	assign cor_pwr = rd_take & (rd_idx == `PEI_IDX_PWR_COR);
	// (R15) signature view clear
	assign cor_sig = rd_take & (rd_idx == `PEI_IDX_SIG_COR);
	// (R18) fault view clear
	assign cor_flt = rd_take & (rd_idx == `PEI_IDX_FLT_COR);
	assign cor_start = rd_take & (rd_idx == `PEI_IDX_START_COR);
	assign cor_sup = rd_take & (rd_idx == `PEI_IDX_SUP_COR);

	always_comb begin
		clr.power = {8{cor_pwr}};
		clr.sigclass = {8{cor_sig}};
		clr.fault = {8{cor_flt}};
		clr.startup = {8{cor_start}};
		clr.supply = {8{cor_sup}};
	end

	always_comb begin
		summary = 8'h00;
		// (R1) switch group
		summary[`PEI_SUM_PWR_SW] = |flags.power[3:0];
		// (R2) power-good group
		summary[`PEI_SUM_PWR_GOOD] = |flags.power[7:4];
		// (R3) low fault nibble
		summary[`PEI_SUM_OVERLOAD] = |flags.fault[3:0];
		// (R4) signature group
		summary[`PEI_SUM_SIG] = |flags.sigclass[3:0];
		// (R5) class group
		summary[`PEI_SUM_CLASS] = |flags.sigclass[7:4];
		// (R6) high fault nibble
		summary[`PEI_SUM_UNPLUG] = |flags.fault[7:4];
		// (R7) start-up group
		summary[`PEI_SUM_START] = |flags.startup;
		// (R8) supply group
		summary[`PEI_SUM_SUPPLY] = |flags.supply;
	end

	// (R22) pin follows masked summary
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			irq_n_q <= 1'b1;
			irq_oe_q <= 1'b0;
		end else begin
			irq_n_q <= ~|(summary & mask_q);
			irq_oe_q <= |(summary & mask_q);
		end
	end

	function automatic logic [7:0] reg_read(input logic [5:0] idx, input pei_evt_t f,
		input logic [7:0] sum, input logic [7:0] msk);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			`PEI_IDX_SUMMARY: v = sum;
			`PEI_IDX_MASK: v = msk;
			`PEI_IDX_PWR, `PEI_IDX_PWR_COR: v = f.power;
			`PEI_IDX_SIG, `PEI_IDX_SIG_COR: v = f.sigclass;
			`PEI_IDX_FLT, `PEI_IDX_FLT_COR: v = f.fault;
			`PEI_IDX_START, `PEI_IDX_START_COR: v = f.startup;
			`PEI_IDX_SUP, `PEI_IDX_SUP_COR: v = f.supply;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// Write path: address and data in either order
	assign wr_fire = (wstate_q == PEI_W_IDLE) & aw_got_q & w_got_q;
	assign wr_idx = awaddr_q[7:2];

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			awready_q <= 1'b0;
		end else if (AWVALID && awready_q) begin
			awready_q <= 1'b0;
		end else if (wstate_q == PEI_W_IDLE && !aw_got_q) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			aw_got_q <= 1'b0;
			awaddr_q <= 8'h00;
		end else if (AWVALID && awready_q) begin
			aw_got_q <= 1'b1;
			awaddr_q <= AWADDR;
		end else if (wr_fire) begin
			aw_got_q <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			wready_q <= 1'b0;
		end else if (WVALID && wready_q) begin
			wready_q <= 1'b0;
		end else if (wstate_q == PEI_W_IDLE && !w_got_q) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			w_got_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else if (WVALID && wready_q) begin
			w_got_q <= 1'b1;
			wdata_q <= WDATA;
			wstrb_q <= WSTRB;
		end else if (wr_fire) begin
			w_got_q <= 1'b0;
		end
	end

	// (R9) only the mask is writable
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			mask_q <= `PEI_MASK_RST;
		end else if (wr_fire && wr_idx == `PEI_IDX_MASK && wstrb_q[0]) begin
			mask_q <= wdata_q[7:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			wstate_q <= PEI_W_IDLE;
		end else begin
			case (wstate_q)
				PEI_W_IDLE: begin
					if (wr_fire) begin
						wstate_q <= PEI_W_RESP;
					end
				end
				PEI_W_RESP: begin
					if (BREADY) begin
						wstate_q <= PEI_W_IDLE;
					end
				end
				default: wstate_q <= PEI_W_IDLE;
			endcase
		end
	end

	// Writes to read-only words are dropped with OKAY
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			bvalid_q <= 1'b0;
			bresp_q <= `PEI_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			if (wr_idx > `PEI_IDX_LAST) begin
				bresp_q <= `PEI_RESP_SLVERR;
			end else begin
				bresp_q <= `PEI_RESP_OKAY;
			end
		end else if (wstate_q == PEI_W_RESP && BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	// Read path: one read in flight
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			arready_q <= 1'b0;
		end else if (rd_take) begin
			arready_q <= 1'b0;
		end else if (rstate_q == PEI_R_IDLE) begin
			arready_q <= 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			rstate_q <= PEI_R_IDLE;
		end else begin
			case (rstate_q)
				PEI_R_IDLE: begin
					if (rd_take) begin
						rstate_q <= PEI_R_DATA;
					end
				end
				PEI_R_DATA: begin
					if (RREADY) begin
						rstate_q <= PEI_R_IDLE;
					end
				end
				default: rstate_q <= PEI_R_IDLE;
			endcase
		end
	end

	// Data sampled before the clear lands, so the read sees the flags
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= `PEI_RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= {24'h00_0000, reg_read(rd_idx, flags, summary, mask_q)};
			if (rd_idx > `PEI_IDX_LAST) begin
				rresp_q <= `PEI_RESP_SLVERR;
			end else begin
				rresp_q <= `PEI_RESP_OKAY;
			end
		end else if (rstate_q == PEI_R_DATA && RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	assign AWREADY = awready_q;
	assign WREADY = wready_q;
	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;
	assign ARREADY = arready_q;
	assign RVALID = rvalid_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;
	assign IRQ_N = irq_n_q;
	assign IRQ_N_OE = irq_oe_q;
endmodule
`default_nettype wire

// File: rtl/pei_evt_sync.sv
// Brings raw event levels from the analogue side into the core clock
// and turns each rising level into a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
module pei_evt_sync #(
	parameter int unsigned W = 40
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] lvl,
	output logic [W-1:0] rise
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
				end else begin
					s1_q[i] <= lvl[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
				end
			end
			// Edge taken after the second stage only
			assign rise[i] = s2_q[i] & ~s3_q[i];
		end
	endgenerate
endmodule
`default_nettype wire

// File: rtl/pei_flag_bank.sv
// Sticky event flags: a set pulse holds the flag until a clear.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "pei_cfg.svh"
module pei_flag_bank #(
	parameter int unsigned W = 40
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] flags
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_flag
			// (R21) set beats clear
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					flags[i] <= `PEI_FLAG_RST;
				end else begin
					flags[i] <= set[i] | (flags[i] & ~clr[i]);
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// File: verif/pei_event_chk.sv
// Checker for the event block: bus answers and interrupt pin.
// Assumes it is bound to pei_event_top and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module pei_event_chk (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic [31:0] RDATA,
	input wire logic [1:0] RRESP,
	input wire logic RVALID,
	input wire logic RREADY,
	input wire logic IRQ_N,
	input wire logic IRQ_N_OE
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	property p_oe; IRQ_N_OE == !IRQ_N; endproperty
	a_oe: assert property (p_oe) else $error("pin enable disagrees");
	property p_ar; ARVALID && ARREADY |=> RVALID && !ARREADY; endproperty
	a_ar: assert property (p_ar) else $error("read answer late");
	property p_rdone; RVALID && RREADY |=> !RVALID && !ARREADY ##1 ARREADY; endproperty
	a_rdone: assert property (p_rdone) else $error("read channel reopen wrong");
	property p_b; AWVALID && AWREADY && WVALID && WREADY |=> !BVALID ##1 BVALID; endproperty
	a_b: assert property (p_b) else $error("write answer late");
	property p_bdone; BVALID && BREADY |=> !BVALID && !AWREADY ##1 AWREADY && WREADY; endproperty
	a_bdone: assert property (p_bdone) else $error("write channel reopen wrong");
	// Pin only releases after a clearing read or a mask write
	property p_rise; $rose(IRQ_N) |-> $past(RVALID) || $past(BVALID) || $past(BVALID, 2); endproperty
	a_rise: assert property (p_rise) else $error("pin released without cause");
	property p_resp; ARVALID && ARREADY |=> RRESP == (($past(ARADDR) >= 8'h30) ? 2'h2 : 2'h0); endproperty
	a_resp: assert property (p_resp) else $error("read response code wrong");
	property p_slv; RVALID && RRESP == 2'h2 |-> RDATA == 32'h0; endproperty
	a_slv: assert property (p_slv) else $error("refused read carries data");
endmodule
bind pei_event_top pei_event_chk u_chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .AWVALID(AWVALID), .AWREADY(AWREADY),
	.WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .IRQ_N(IRQ_N),
	.IRQ_N_OE(IRQ_N_OE));
`default_nettype wire

// File: verif/pei_event_top_test.sv
// Bench for the event block: AXI4-Lite host tasks and event pulses.
// Assumes the host model supplies the pulled-up interrupt wire.
`timescale 1ns/10ps
`default_nettype none
module pei_event_top_test import pei_pkg::*;;
	logic CORE_CLK = 1'b0;
	logic NRST = 1'b0;
	logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0, a;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic [31:0] WDATA = 32'h0, RDATA, d;
	logic [3:0] WSTRB = 4'h0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ_N, IRQ_N_OE, irq;
	logic [1:0] BRESP, RRESP, r;
	pei_evt_t ev = '0;
	int fail_count = 0, n_compared = 0, cyc = 0;
	// One event bit per summary group, as positions in the event vector
	int pos [8] = '{2, 7, 19, 9, 14, 21, 28, 37};
	pei_event_top dut (.CORE_CLK(CORE_CLK), .NRST(NRST), .AWADDR(AWADDR), .AWPROT(3'h0), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARPROT(3'h0), .ARVALID(ARVALID), .ARREADY(ARREADY),
		.RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .EVT_PWR_SWITCH(ev.power[3:0]),
		.EVT_PWR_GOOD(ev.power[7:4]), .EVT_SIG_DONE(ev.sigclass[3:0]), .EVT_CLASS_DONE(ev.sigclass[7:4]),
		.EVT_OVERLOAD(ev.fault[3:0]), .EVT_UNPLUG(ev.fault[7:4]), .EVT_INRUSH(ev.startup[3:0]),
		.EVT_LIMIT(ev.startup[7:4]), .EVT_OVERTEMP(ev.supply[7]), .EVT_VDD_UV(ev.supply[5]),
		.EVT_VEE_UV(ev.supply[4]), .IRQ_N(IRQ_N), .IRQ_N_OE(IRQ_N_OE));
	pei_host_model host (.IRQ_N(IRQ_N), .IRQ_N_OE(IRQ_N_OE), .irq_line(irq));
	always #25 CORE_CLK = ~CORE_CLK;
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			summarize();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] v, input logic [3:0] s, output logic [1:0] rsp);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		AWADDR <= ad;
		WDATA <= {24'h0, v};
		WSTRB <= s;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (!(aw && w)) begin
			@(posedge CORE_CLK);
			if (AWVALID && AWREADY) begin
				aw = 1'b1;
				AWVALID <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w = 1'b1;
				WVALID <= 1'b0;
			end
		end
		do @(posedge CORE_CLK); while (!BVALID);
		rsp = BRESP;
		BREADY <= 1'b0;
		@(posedge CORE_CLK);
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] v, output logic [1:0] rsp);
		ARADDR <= ad;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge CORE_CLK); while (!ARREADY);
		ARVALID <= 1'b0;
		do @(posedge CORE_CLK); while (!RVALID);
		v = RDATA;
		rsp = RRESP;
		RREADY <= 1'b0;
		@(posedge CORE_CLK);
	endtask
	initial begin
		repeat (10) @(posedge CORE_CLK);
		NRST <= 1'b1;
		@(posedge CORE_CLK);
		rd(8'h04, d, r);
		chk(d, 32'h0);
		chk(irq, 1'b1);
		wr(8'h00, 8'hff, 4'hf, r);
		chk(r, 2'h0);
		wr(8'h04, 8'ha5, 4'h0, r);
		rd(8'h04, d, r);
		chk(d, 32'h0);
		rd(8'h30, d, r);
		chk(d, 32'h0);
		chk(r, 2'h2);
		wr(8'h30, 8'h00, 4'h1, r);
		chk(r, 2'h2);
		$display("test access done");
		// Summary groups one event each
		for (int g = 0; g < 8; g++) begin
			a = 8'((2 + 2 * (pos[g] / 8)) * 4);
			wr(8'h04, 8'h01 << g, 4'h1, r);
			ev[pos[g]] <= 1'b1;
			repeat (4) @(posedge CORE_CLK);
			ev[pos[g]] <= 1'b0;
			repeat (2) @(posedge CORE_CLK);
			chk(irq, 1'b0);
			rd(8'h00, d, r);
			chk(d, 32'h1 << g);
			rd(a, d, r);
			chk(d, 32'h1 << (pos[g] % 8));
			rd(a + 8'h4, d, r);
			chk(d, 32'h1 << (pos[g] % 8));
			rd(a, d, r);
			chk(d, 32'h0);
			chk(irq, 1'b1);
			$display("test group %0d done", g);
		end
		wr(8'h04, 8'h00, 4'h1, r);
		ev.sigclass <= 8'h81;
		ev.supply <= 8'hb0;
		ev.fault <= 8'h01;
		repeat (4) @(posedge CORE_CLK);
		ev <= '0;
		repeat (2) @(posedge CORE_CLK);
		chk(irq, 1'b1);
		rd(8'h00, d, r);
		chk(d, 32'h9c);
		rd(8'h14, d, r);
		chk(d, 32'h81);
		rd(8'h2c, d, r);
		chk(d, 32'hb0);
		rd(8'h1c, d, r);
		chk(d, 32'h01);
		rd(8'h00, d, r);
		chk(d, 32'h0);
		$display("test masked done");
		summarize();
	end
endmodule
`default_nettype wire

// File: verif/pei_host_model.sv
// Host side of the interrupt pin: open-drain wire with a pull-up.
// Assumes the device drives the pin only while its enable is high.
`timescale 1ns/10ps
`default_nettype none
module pei_host_model (
	input wire logic IRQ_N,
	input wire logic IRQ_N_OE,
	output logic irq_line
);
	assign irq_line = IRQ_N_OE ? IRQ_N : 1'b1;
endmodule
`default_nettype wire
